// ### design/itmr_params.svh
// Constants of the interval timer host port: decode codes, field
// positions and reset values. Included by the package and the core.
`ifndef ITMR_PARAMS_SVH
`define ITMR_PARAMS_SVH

// ----------------------------------------------------------------
// Bus decode
// ----------------------------------------------------------------
`define ITMR_NUM_CNT      3
`define ITMR_SEL_CW       2'h3
`define ITMR_SYNC_DEPTH   2

// ----------------------------------------------------------------
// Control word field positions
// ----------------------------------------------------------------
`define ITMR_CW_SEL_MSB   7
`define ITMR_CW_SEL_LSB   6
`define ITMR_CW_FMT_MSB   5
`define ITMR_CW_FMT_LSB   4
`define ITMR_CW_MODE_MSB  3
`define ITMR_CW_MODE_LSB  1
`define ITMR_CW_BCD_BIT   0

// ----------------------------------------------------------------
// Field codes
// ----------------------------------------------------------------
`define ITMR_FMT_LATCH    2'h0
`define ITMR_FMT_LO       2'h1
`define ITMR_FMT_HI       2'h2
`define ITMR_FMT_LOHI     2'h3
`define ITMR_SEL_BAD      2'h3

// ----------------------------------------------------------------
// Reset and count values
// ----------------------------------------------------------------
`define ITMR_CW_RST       8'h00
`define ITMR_CNT_ZERO     16'h0000
`define ITMR_CNT_ONE      16'h0001
`define ITMR_CNT_TWO      16'h0002
`define ITMR_OUT_RST      1'b1

`endif

// ### design/itmr_pkg.sv
// Types of the interval timer host port.
// Assumes itmr_params.svh is on the include path.
`include "itmr_params.svh"

package itmr_pkg;

    // Control word as written by the host
    typedef struct packed {
        logic [1:0] sel;
        logic [1:0] fmt;
        logic [2:0] mode;
        logic       bcd;
    } itmr_cw_t;

    // Phase of a two-byte count load
    typedef enum logic [1:0] {
        ITMR_LD_LO = 2'b01,
        ITMR_LD_HI = 2'b10
    } itmr_ld_t;

    // Synchronised view of the host bus pins
    typedef struct packed {
        logic       cs_n;
        logic       rd_n;
        logic       wr_n;
        logic [1:0] sel;
        logic [7:0] data;
    } itmr_bus_t;

endpackage

// ### design/itmr_core.sv
// Three-channel 16-bit down-counter timer behind an 8-bit host port.
// Assumes every pin is asynchronous to clk_sys_i and changes slowly
// against it: host strobes last several system clocks, counter clocks
// run well below half the system clock rate.
`timescale 1ns/1ps
`include "itmr_params.svh"

// Notes on behaviour
// - Deselected: float bus, ignore strobes, hold state
// - Eight-bit three-state bidirectional data port
// - Two select lines pick counter or control
// - Write with select 11 loads control word
// - Write select 00/01/10 loads counter 0/1/2
// - Read select 00/01/10 returns counter 0/1/2
// - Selected, no strobe: data pins float
// - Control word fields: select, format, mode, decimal
// - Select 00/01/10 counters; 11 illegal
// - Format: latch, low, high, low-then-high
// - Mode decode, top bit ignored for 2, 3
// - Binary sixteen-bit or four-digit decimal counting
// - Control write clears count to zero
// - Some modes start counting right after load
// - Gate starts, suspends, resumes per mode
// - Own clock per counter drives own output
// - Mode 0: low on set, high at end
// - Latch command freezes value, counting continues
module itmr_core (
    input  wire logic       clk_sys_i,
    input  wire logic       sys_rst_i,
    input  wire logic       chip_sel_n_i,
    input  wire logic       read_n_i,
    input  wire logic       write_n_i,
    input  wire logic [1:0] register_select_i,
    input  wire logic [7:0] host_data_bus_i,
    output logic      [7:0] host_data_bus_o,
    output logic            host_data_bus_oe_n_o,
    input  wire logic [2:0] counter_clock_i,
    input  wire logic [2:0] counter_gate_i,
    output logic      [2:0] counter_output_o
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------

    // One step down, binary or four decimal digits
    function automatic logic [15:0] itmr_dec(input logic [15:0] v,
                                             input logic        bcd);
        logic [15:0] r;
        logic        brw;
        r   = v;
        brw = 1'b1;
        if (!bcd)
            r = v - 16'h0001;
        else
        begin
            for (int k = 0; k < 4; k++)
            begin
                if (brw)
                begin
                    if (v[k*4 +: 4] == 4'h0)
                        r[k*4 +: 4] = 4'h9;
                    else
                    begin
                        r[k*4 +: 4] = v[k*4 +: 4] - 4'h1;
                        brw = 1'b0;
                    end
                end
            end
        end
        return r;
    endfunction

    // Folds the ignored top bit of modes 2 and 3
    function automatic logic [2:0] itmr_mode(input logic [2:0] m);
        return m[1] ? {1'b0, m[1:0]} : m;
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    itmr_pkg::itmr_bus_t bus_s1_ff;
    itmr_pkg::itmr_bus_t bus_s2_ff;
    itmr_pkg::itmr_bus_t bus_p_ff;
    logic [2:0]          cclk_s1_ff;
    logic [2:0]          cclk_s2_ff;
    logic [2:0]          cclk_p_ff;
    logic [2:0]          gate_s1_ff;
    logic [2:0]          gate_s2_ff;
    logic [2:0]          gate_p_ff;

    // Two stages, then a third copy for edge detection and for the strobe decode's select, data and chip select; the bus drive decodes the second stage
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            bus_s1_ff  <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                           sel: 2'h0, data: 8'h00};
            bus_s2_ff  <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                           sel: 2'h0, data: 8'h00};
            bus_p_ff   <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                           sel: 2'h0, data: 8'h00};
            cclk_s1_ff <= 3'h0;
            cclk_s2_ff <= 3'h0;
            cclk_p_ff  <= 3'h0;
            gate_s1_ff <= 3'h0;
            gate_s2_ff <= 3'h0;
            gate_p_ff  <= 3'h0;
        end
        else
        begin
            bus_s1_ff  <= '{cs_n: chip_sel_n_i, rd_n: read_n_i,
                           wr_n: write_n_i, sel: register_select_i,
                           data: host_data_bus_i};
            bus_s2_ff  <= bus_s1_ff;
            bus_p_ff   <= bus_s2_ff;
            cclk_s1_ff <= counter_clock_i;
            cclk_s2_ff <= cclk_s1_ff;
            cclk_p_ff  <= cclk_s2_ff;
            gate_s1_ff <= counter_gate_i;
            gate_s2_ff <= gate_s1_ff;
            gate_p_ff  <= gate_s2_ff;
        end
    end

    // ----------------------------------------------------------------
    // Strobe decode
    // ----------------------------------------------------------------
    logic                 wr_end;
    logic                 rd_end;
    itmr_pkg::itmr_cw_t   cw_in;

    // Act at the trailing edge of a strobe while selected; data and
    // select are taken one stage before the edge, where they were held
    assign wr_end = !bus_p_ff.cs_n && !bus_p_ff.wr_n && bus_p_ff.rd_n
                    && bus_s2_ff.wr_n;
    assign rd_end = !bus_p_ff.cs_n && !bus_p_ff.rd_n && bus_p_ff.wr_n
                    && bus_s2_ff.rd_n;
    assign cw_in  = itmr_pkg::itmr_cw_t'(bus_p_ff.data);

    // ----------------------------------------------------------------
    // Counters
    // ----------------------------------------------------------------
    logic [7:0] rd_byte [`ITMR_NUM_CNT];

    for (genvar i = 0; i < `ITMR_NUM_CNT; i++)
    begin : g_cnt
        itmr_pkg::itmr_cw_t cw_ff;
        itmr_pkg::itmr_ld_t ld_ff;
        logic [15:0]        cnt_ff;
        logic [15:0]        rld_ff;
        logic [15:0]        lat_ff;
        logic               out_ff;
        logic               pend_ff;
        logic               run_ff;
        logic               trig_ff;
        logic               lat_v_ff;
        logic               rd_hi_ff;
        logic               cw_wr;
        logic               lt_wr;
        logic               ld_wr;
        logic               tick;
        logic               gate;
        logic               gate_rise;
        logic [2:0]         mode;
        logic [15:0]        dec1;
        logic [15:0]        src;
        logic               odd;

        // Control word goes to the counter its select field names;
        // select 11 matches no counter and is dropped
        assign cw_wr = wr_end && bus_p_ff.sel == `ITMR_SEL_CW
                       && cw_in.sel == 2'(i)
                       && cw_in.fmt != `ITMR_FMT_LATCH;
        assign lt_wr = wr_end && bus_p_ff.sel == `ITMR_SEL_CW
                       && cw_in.sel == 2'(i)
                       && cw_in.fmt == `ITMR_FMT_LATCH;
        assign ld_wr = wr_end && bus_p_ff.sel == 2'(i);
        // Counting advances on the falling edge of the counter clock
        assign tick      = cclk_p_ff[i] && !cclk_s2_ff[i];
        assign gate      = gate_s2_ff[i];
        assign gate_rise = gate_s2_ff[i] && !gate_p_ff[i];
        assign mode      = itmr_mode(cw_ff.mode);
        assign dec1      = itmr_dec(cnt_ff, cw_ff.bcd);
        assign odd       = rld_ff[0];

        // Loading, gating and counting
        always_ff @(posedge clk_sys_i)
        begin
            if (sys_rst_i)
            begin
                cw_ff   <= itmr_pkg::itmr_cw_t'(`ITMR_CW_RST);
                ld_ff   <= itmr_pkg::ITMR_LD_LO;
                cnt_ff  <= `ITMR_CNT_ZERO;
                rld_ff  <= `ITMR_CNT_ZERO;
                out_ff  <= `ITMR_OUT_RST;
                pend_ff <= 1'b0;
                run_ff  <= 1'b0;
                trig_ff <= 1'b0;
            end
            else if (cw_wr)
            begin
                cw_ff   <= cw_in;
                cnt_ff  <= `ITMR_CNT_ZERO;
                ld_ff   <= itmr_pkg::ITMR_LD_LO;
                out_ff  <= itmr_mode(cw_in.mode) != 3'h0;
                pend_ff <= 1'b0;
                run_ff  <= 1'b0;
                trig_ff <= 1'b0;
            end
            else if (ld_wr)
            begin
                unique case (cw_ff.fmt)
                    `ITMR_FMT_LO:
                    begin
                        rld_ff  <= {8'h00, bus_p_ff.data};
                        pend_ff <= 1'b1;
                    end
                    `ITMR_FMT_HI:
                    begin
                        rld_ff  <= {bus_p_ff.data, 8'h00};
                        pend_ff <= 1'b1;
                    end
                    default:
                    begin
                        // Host keeps low then high back to back
                        if (ld_ff == itmr_pkg::ITMR_LD_LO)
                        begin
                            rld_ff[7:0] <= bus_p_ff.data;
                            ld_ff       <= itmr_pkg::ITMR_LD_HI;
                            if (mode == 3'h0)
                                run_ff <= 1'b0;
                        end
                        else
                        begin
                            rld_ff[15:8] <= bus_p_ff.data;
                            ld_ff        <= itmr_pkg::ITMR_LD_LO;
                            pend_ff      <= 1'b1;
                        end
                    end
                endcase
            end
            else
            begin
                // Gate edge arms the hardware-started modes
                if (gate_rise && mode != 3'h0)
                    trig_ff <= 1'b1;
                // Gate low holds rate outputs high
                if (!gate && (mode == 3'h2 || mode == 3'h3))
                    out_ff <= 1'b1;
                if (tick)
                begin
                    unique case (mode)
                        3'h0, 3'h4:
                        begin
                            // Strobe lasts one counter clock
                            if (mode == 3'h4 && !out_ff)
                                out_ff <= 1'b1;
                            if (pend_ff || (trig_ff && mode == 3'h4))
                            begin
                                cnt_ff  <= rld_ff;
                                pend_ff <= 1'b0;
                                trig_ff <= 1'b0;
                                run_ff  <= 1'b1;
                                if (mode == 3'h0)
                                    out_ff <= 1'b0;
                            end
                            else if (run_ff && gate)
                            begin
                                cnt_ff <= dec1;
                                if (cnt_ff == `ITMR_CNT_ONE)
                                begin
                                    out_ff <= mode == 3'h0;
                                    run_ff <= mode == 3'h0;
                                end
                            end
                        end
                        3'h1, 3'h5:
                        begin
                            if (mode == 3'h5 && !out_ff)
                                out_ff <= 1'b1;
                            if (trig_ff)
                            begin
                                cnt_ff  <= rld_ff;
                                trig_ff <= 1'b0;
                                run_ff  <= 1'b1;
                                if (mode == 3'h1)
                                    out_ff <= 1'b0;
                            end
                            else if (run_ff)
                            begin
                                cnt_ff <= dec1;
                                if (cnt_ff == `ITMR_CNT_ONE)
                                begin
                                    out_ff <= mode == 3'h1;
                                    run_ff <= 1'b0;
                                end
                            end
                        end
                        3'h2:
                        begin
                            if (gate && (pend_ff || trig_ff))
                            begin
                                cnt_ff  <= rld_ff;
                                pend_ff <= 1'b0;
                                trig_ff <= 1'b0;
                                run_ff  <= 1'b1;
                            end
                            else if (gate && run_ff)
                            begin
                                if (cnt_ff == `ITMR_CNT_TWO)
                                begin
                                    out_ff <= 1'b0;
                                    cnt_ff <= dec1;
                                end
                                else if (cnt_ff == `ITMR_CNT_ONE)
                                begin
                                    out_ff <= 1'b1;
                                    cnt_ff <= rld_ff;
                                end
                                else
                                    cnt_ff <= dec1;
                            end
                        end
                        3'h3:
                        begin
                            // Odd counts give the high half one extra
                            // clock; the +1 is binary, so odd decimal
                            // counts ending in 9 are not supported
                            if (gate && (pend_ff || trig_ff))
                            begin
                                cnt_ff  <= rld_ff + {15'h0, odd};
                                pend_ff <= 1'b0;
                                trig_ff <= 1'b0;
                                run_ff  <= 1'b1;
                                out_ff  <= 1'b1;
                            end
                            else if (gate && run_ff)
                            begin
                                if (cnt_ff == `ITMR_CNT_TWO)
                                begin
                                    out_ff <= !out_ff;
                                    cnt_ff <= out_ff
                                        ? rld_ff - {15'h0, odd}
                                        : rld_ff + {15'h0, odd};
                                end
                                else
                                    cnt_ff <= itmr_dec(dec1, cw_ff.bcd);
                            end
                        end
                        default:
                        begin
                            run_ff <= 1'b0;
                        end
                    endcase
                end
            end
        end

        // Latch and read-back byte order
        always_ff @(posedge clk_sys_i)
        begin
            if (sys_rst_i || cw_wr)
            begin
                lat_ff   <= `ITMR_CNT_ZERO;
                lat_v_ff <= 1'b0;
                rd_hi_ff <= 1'b0;
            end
            else
            begin
                // A second latch before read-out keeps the first value
                if (lt_wr && !lat_v_ff)
                begin
                    lat_ff   <= cnt_ff;
                    lat_v_ff <= 1'b1;
                end
                else if (rd_end && bus_p_ff.sel == 2'(i))
                begin
                    if (cw_ff.fmt == `ITMR_FMT_LOHI)
                        rd_hi_ff <= !rd_hi_ff;
                    if (cw_ff.fmt != `ITMR_FMT_LOHI || rd_hi_ff)
                        lat_v_ff <= 1'b0;
                end
            end
        end

        // Direct reads see the live count; unsettled mid-count
        assign src = lat_v_ff ? lat_ff : cnt_ff;
        assign rd_byte[i] = (cw_ff.fmt == `ITMR_FMT_HI
                             || (cw_ff.fmt == `ITMR_FMT_LOHI && rd_hi_ff))
                            ? src[15:8] : src[7:0];
        assign counter_output_o[i] = out_ff;
    end

    // ----------------------------------------------------------------
    // Data bus drive
    // ----------------------------------------------------------------

    // Drive only during a selected read of a counter; else float
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            host_data_bus_o      <= 8'h00;
            host_data_bus_oe_n_o <= 1'b1;
        end
        else
        begin
            host_data_bus_oe_n_o <= bus_s2_ff.cs_n || bus_s2_ff.rd_n
                                    || !bus_s2_ff.wr_n
                                    || bus_s2_ff.sel == `ITMR_SEL_CW;
            if (bus_s2_ff.sel != `ITMR_SEL_CW)
                host_data_bus_o <= rd_byte[bus_s2_ff.sel];
        end
    end

endmodule // itmr_core

// ### verif/itmr_core_assertions.sv
// Pin-level assertions on the timer host port.
// Bound to itmr_core; sees its ports only, one clock domain.
`timescale 1ns/1ps
module itmr_core_assertions (
    input wire logic       clk_sys_i,
    input wire logic       sys_rst_i,
    input wire logic       chip_sel_n_i,
    input wire logic       read_n_i,
    input wire logic       write_n_i,
    input wire logic [1:0] register_select_i,
    input wire logic [7:0] host_data_bus_i,
    input wire logic [7:0] host_data_bus_o,
    input wire logic       host_data_bus_oe_n_o,
    input wire logic [2:0] counter_clock_i,
    input wire logic [2:0] counter_gate_i,
    input wire logic [2:0] counter_output_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);
    logic [3:0] age_ff;
    // ----------------------------------------
    // Cause tracking for counter 0
    // ----------------------------------------
    // Cycles since a tick, gate change or write strobe; output 0 may move only soon after one
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i || $fell(counter_clock_i[0]) || $rose(write_n_i) || $changed(counter_gate_i[0]))
            age_ff <= 4'h0;
        else if (age_ff != 4'hf)
            age_ff <= age_ff + 4'h1;
    end
    // Control word for counter 0, mode 0, not a latch command
    sequence s_cw0;
        (!chip_sel_n_i && read_n_i && !write_n_i && register_select_i == 2'h3 && host_data_bus_i[7:6] == 2'h0
            && host_data_bus_i[5:4] != 2'h0 && host_data_bus_i[3:1] == 3'h0) [*4] ##1 write_n_i;
    endsequence
    sequence s_rd_cnt;
        (!chip_sel_n_i && !read_n_i && write_n_i && register_select_i != 2'h3) [*5];
    endsequence
    a_desel_float: assert property (chip_sel_n_i [*5] |-> host_data_bus_oe_n_o)
        else $error("bus driven while deselected");
    a_idle_float: assert property ((!chip_sel_n_i && read_n_i && write_n_i) [*5] |-> host_data_bus_oe_n_o)
        else $error("bus driven without strobe");
    a_cw_noread: assert property ((!chip_sel_n_i && !read_n_i && register_select_i == 2'h3) [*5] |-> host_data_bus_oe_n_o)
        else $error("control word driven on read");
    a_read_drive: assert property (s_rd_cnt |-> !host_data_bus_oe_n_o)
        else $error("counter read not driven");
    a_read_release: assert property ($rose(read_n_i) |-> ##[1:5] host_data_bus_oe_n_o)
        else $error("bus not released after read");
    a_out_reset: assert property ($fell(sys_rst_i) |-> counter_output_o == 3'h7)
        else $error("outputs not high after reset");
    a_mode0_low: assert property (s_cw0 |-> ##[1:6] !counter_output_o[0])
        else $error("mode 0 output not low");
    a_out_cause: assert property ($changed(counter_output_o[0]) |-> age_ff <= 4'h8)
        else $error("output 0 moved without cause");
endmodule // itmr_core_assertions

bind itmr_core itmr_core_assertions u_chk (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .chip_sel_n_i(chip_sel_n_i),
    .read_n_i(read_n_i),
    .write_n_i(write_n_i),
    .register_select_i(register_select_i),
    .host_data_bus_i(host_data_bus_i),
    .host_data_bus_o(host_data_bus_o),
    .host_data_bus_oe_n_o(host_data_bus_oe_n_o),
    .counter_clock_i(counter_clock_i),
    .counter_gate_i(counter_gate_i),
    .counter_output_o(counter_output_o)
);

// ### verif/itmr_host_model.sv
// Processor model on the timer's 8-bit host bus.
// Assumes clk_i is the timer's system clock.
`timescale 1ns/1ps
module itmr_host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] dev_data_i,
    input  wire logic       dev_oe_n_i,
    output logic            chip_sel_n_o,
    output logic            read_n_o,
    output logic            write_n_o,
    output logic      [1:0] register_select_o,
    output logic      [7:0] bus_level_o
);
    logic       drive_ff;
    logic [7:0] wdata_ff;
    logic [7:0] float_ff;
    // Idle bus: nothing selected, no strobe
    initial
    begin
        chip_sel_n_o      = 1'b1;
        read_n_o          = 1'b1;
        write_n_o         = 1'b1;
        register_select_o = 2'h0;
        drive_ff          = 1'b0;
        wdata_ff          = 8'h00;
        float_ff          = 8'h5a;
    end
    // A floating wire keeps toggling so it never passes for data
    always @(posedge clk_i)
        float_ff <= ~float_ff;
    assign bus_level_o = drive_ff ? wdata_ff : (!dev_oe_n_i ? dev_data_i : float_ff);
    // Select and data settle two clocks before the strobe and stay three after
    task automatic write_cycle(input logic cs_n, input logic [1:0] s, input logic [7:0] d);
        @(posedge clk_i);
        chip_sel_n_o      <= cs_n;
        register_select_o <= s;
        wdata_ff          <= d;
        drive_ff          <= 1'b1;
        repeat (2) @(posedge clk_i);
        write_n_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        write_n_o <= 1'b1;
        repeat (3) @(posedge clk_i);
        chip_sel_n_o <= 1'b1;
        drive_ff     <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    // Data taken at the edge that ends the strobe
    task automatic read_cycle(input logic [1:0] s, output logic [7:0] d);
        @(posedge clk_i);
        chip_sel_n_o      <= 1'b0;
        register_select_o <= s;
        repeat (2) @(posedge clk_i);
        read_n_o <= 1'b0;
        repeat (5) @(posedge clk_i);
        d = bus_level_o;
        read_n_o <= 1'b1;
        repeat (3) @(posedge clk_i);
        chip_sel_n_o <= 1'b1;
        repeat (4) @(posedge clk_i);
    endtask
endmodule // itmr_host_model

// ### verif/interval_timer_host_port_tb.sv
// Self-checking bench for the timer host port.
// Host pins come from the model; counter clocks and gates are driven here.
`timescale 1ns/1ps
module interval_timer_host_port_tb;
    logic       clk;
    logic       rst;
    logic [2:0] cclk;
    logic [2:0] gate;
    logic [2:0] cout;
    logic [7:0] bus;
    logic [7:0] dout;
    logic       oe_n;
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic [1:0] sel;
    logic [7:0] junk;
    int         fails = 0;
    int         compares = 0;
    int         cycles = 0;
    itmr_core uut (.clk_sys_i(clk), .sys_rst_i(rst), .chip_sel_n_i(cs_n), .read_n_i(rd_n), .write_n_i(wr_n),
        .register_select_i(sel), .host_data_bus_i(bus), .host_data_bus_o(dout), .host_data_bus_oe_n_o(oe_n),
        .counter_clock_i(cclk), .counter_gate_i(gate), .counter_output_o(cout));
    itmr_host_model host (.clk_i(clk), .dev_data_i(dout), .dev_oe_n_i(oe_n), .chip_sel_n_o(cs_n),
        .read_n_o(rd_n), .write_n_o(wr_n), .register_select_o(sel), .bus_level_o(bus));
    // System clock, 10 ns
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic print_verdict();
        if (fails == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Hang guard, far above the roughly 600 cycles the tests need
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            fails++;
            print_verdict();
        end
    end
    task automatic chk_out(input logic [2:0] exp);
        @(negedge clk); // Away from the edge that moves them
        compares++;
        if (cout !== exp)
        begin
            fails++;
            $display("ERROR %0t: outputs %b, expected %b", $time, cout, exp);
        end
    endtask
    task automatic rd_chk(input logic [1:0] s, input logic [7:0] exp);
        logic [7:0] b;
        host.read_cycle(s, b);
        compares++;
        if (b !== exp)
        begin
            fails++;
            $display("ERROR %0t: read %h, expected %h", $time, b, exp);
        end
    endtask
    task automatic wr(input logic [1:0] s, input logic [7:0] d);
        host.write_cycle(1'b0, s, d);
    endtask
    // One falling edge on a counter clock; slow against the system clock
    task automatic tick(input int k);
        @(posedge clk);
        cclk[k] <= 1'b0;
        repeat (4) @(posedge clk);
        cclk[k] <= 1'b1;
        repeat (5) @(posedge clk);
    endtask
    // Main sequence
    initial
    begin
        rst  = 1'b1;
        cclk = 3'h7;
        gate = 3'h7;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk_out(3'h7);
        wr(2'h3, 8'h30);
        chk_out(3'h6);
        wr(2'h0, 8'h05);
        wr(2'h0, 8'h00);
        repeat (5) tick(0);
        chk_out(3'h6);
        tick(0);
        chk_out(3'h7);
        host.write_cycle(1'b1, 2'h3, 8'h30);
        chk_out(3'h7);
        wr(2'h3, 8'h70);
        wr(2'h1, 8'h34);
        wr(2'h1, 8'h12);
        repeat (3) tick(1);
        wr(2'h3, 8'h40);
        tick(1);
        rd_chk(2'h1, 8'h32);
        rd_chk(2'h1, 8'h12);
        @(posedge clk);
        gate[1] <= 1'b0;
        tick(1);
        rd_chk(2'h1, 8'h31);
        rd_chk(2'h1, 8'h12);
        wr(2'h3, 8'h31);
        wr(2'h0, 8'h10);
        wr(2'h0, 8'h00);
        repeat (2) tick(0);
        @(posedge clk);
        gate[0] <= 1'b0;
        rd_chk(2'h0, 8'h09);
        rd_chk(2'h0, 8'h00);
        wr(2'h3, 8'h9c);
        wr(2'h2, 8'h03);
        repeat (2) tick(2);
        chk_out(3'h4);
        tick(2);
        chk_out(3'h0);
        tick(2);
        chk_out(3'h4);
        @(posedge clk);
        gate[2] <= 1'b0;
        tick(2);
        rd_chk(2'h2, 8'h03);
        host.read_cycle(2'h3, junk);
        for (int i = 0; i < 8; i++)
        begin
            wr(2'h3, {2'b10, 2'b10, i[2:0], 1'b0});
            chk_out({i != 0, 2'b00});
        end
        wr(2'h3, 8'hf0);
        chk_out(3'h4);
        print_verdict();
    end
endmodule // interval_timer_host_port_tb
